/* File: egp_params.svh */
`ifndef EGP_PARAMS_SVH
`define EGP_PARAMS_SVH

// register indices; byte address is four times the index
`define EGP_IDX_PJ_DATA        6'h28
`define EGP_IDX_PJ_PIN_INPUT   6'h29
`define EGP_IDX_PJ_DIRECTION   6'h2A
`define EGP_IDX_PJ_DRIVE       6'h2B
`define EGP_IDX_PJ_PULL        6'h2C
`define EGP_IDX_PJ_POLARITY    6'h2D
`define EGP_IDX_PJ_IRQ_ENABLE  6'h2E
`define EGP_IDX_PJ_IRQ_FLAGS   6'h2F
`define EGP_IDX_AD_DATA        6'h30
`define EGP_IDX_AD_PIN_INPUT   6'h31
`define EGP_IDX_AD_DIRECTION   6'h32
`define EGP_IDX_PJ_WIRED_OR    6'h3C

// field layout of the two-pin port inside an 8-bit register
`define EGP_PJ_LSB             3'h6
`define EGP_PJ_MSB             3'h7

// reset values
`define EGP_RST_PJ             2'h0
`define EGP_RST_AD             8'h00

// bus responses
`define EGP_RESP_OKAY          2'h0
`define EGP_RESP_SLVERR        2'h2

// synchroniser depth and priming length
`define EGP_SYNC_STAGES        3

`endif

/* File: egp_pkg.sv */
package egp_pkg;

   typedef enum logic [1:0]
   {
      EGP_WR_IDLE = 2'h1,
      EGP_WR_RESP = 2'h2
   } egp_wr_e;

   typedef enum logic [1:0]
   {
      EGP_RD_IDLE = 2'h1,
      EGP_RD_DATA = 2'h2
   } egp_rd_e;

endpackage

/* File: egp_sync.sv */
`include "egp_params.svh"

module egp_sync
   import egp_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   // clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // raw pin levels
   input  wire logic [WIDTH-1:0] pin_raw,
   // synchronised levels
   output logic      [WIDTH-1:0] pin_sync,
   output logic                  primed
);

   logic [WIDTH-1:0]                s1_reg;
   logic [WIDTH-1:0]                s2_reg;
   logic [WIDTH-1:0]                s3_reg;
   logic [WIDTH-1:0]                held_reg;
   logic [`EGP_SYNC_STAGES-1:0]     fill_reg;
   logic [WIDTH-1:0]                agree;

   // a change counts once stages two and three agree
   assign agree    = ~(s2_reg ^ s3_reg);
   assign pin_sync = (agree & s3_reg) | (~agree & held_reg);
   assign primed   = fill_reg[`EGP_SYNC_STAGES-1];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_reg   <= '0;
         s2_reg   <= '0;
         s3_reg   <= '0;
         held_reg <= '0;
         fill_reg <= '0;
      end
      else
      begin
         s1_reg   <= pin_raw;
         s2_reg   <= s1_reg;
         s3_reg   <= s2_reg;
         held_reg <= pin_sync;
         fill_reg <= {fill_reg[`EGP_SYNC_STAGES-2:0], 1'b1};
      end
   end

endmodule

/* File: egp_edge_flag.sv */
module egp_edge_flag
   import egp_pkg::*;
(
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // synchronised pin and its controls
   input  wire logic level,
   input  wire logic primed,
   input  wire logic polarity,
   input  wire logic clear,
   // sticky flag
   output logic      flag
);

   logic prev_reg;
   logic armed_reg;
   logic flag_reg;
   logic rise;
   logic fall;
   logic edge_hit;
   logic flag_next;

   assign rise      = armed_reg & level & ~prev_reg;
   assign fall      = armed_reg & ~level & prev_reg;
   assign edge_hit  = polarity ? rise : fall;
   // an edge in the cycle of a clear keeps the flag set
   assign flag_next = edge_hit | (flag_reg & ~clear);
   assign flag      = flag_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prev_reg  <= 1'b0;
         armed_reg <= 1'b0;
         flag_reg  <= 1'b0;
      end
      else
      begin
         prev_reg  <= level;
         armed_reg <= primed;
         flag_reg  <= flag_next;
      end
   end

endmodule

/* File: egp_top.sv */
// Contract
// - each port-J direction bit makes pin 7 or 6 an input at 0 and an output at 1.
// - after a direction change the data and pin-input reads may settle within two bus cycles.
// - a drive-strength bit gives full drive at 0 and about a third at 1, only while output.
// - a pull-enable bit turns the pull device on at 1, only for an input or wired-or output.
// - a polarity bit selects a falling edge at 0 and a rising edge at 1 for the flag.
// - with pull enabled on an input, polarity 0 gives a pull-up and 1 a pull-down.
// - an interrupt-enable bit masks the pin's interrupt at 0 and permits it at 1.
// - the selected edge on a pin sets its interrupt flag; 0 means nothing pending.
// - writing 1 to a flag bit clears it and writing 0 leaves it alone.
// - an interrupt is requested while any flag is set together with its enable.
// - direction, pull-enable and interrupt-enable registers are readable and writable always.
// - analog data reads the stored value where direction is 1, else the pin level.
// - analog pin-input reads the pins always and ignores writes.
// - port-J data reads stored value where direction is 1, else the pin; pin-input reads pins.
// - a pin under peripheral control ignores its direction bit.
//
// Local design decision: the AXI4-Lite interface to the registers.
`include "egp_params.svh"

module egp_top
   import egp_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int AD_W   = 8
)
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // axi4-lite read data
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // interrupt
   output logic                   irq,
   // port j pins 7 and 6
   input  wire logic [1:0]        pj_pin_i,
   output logic [1:0]             pj_pin_o,
   output logic [1:0]             pj_pin_oe,
   output logic [1:0]             pj_drive_reduced,
   output logic [1:0]             pj_pull_enable_o,
   output logic [1:0]             pj_pull_up,
   // peripheral takeover of port j
   input  wire logic [1:0]        pj_periph_en,
   input  wire logic [1:0]        pj_periph_out,
   input  wire logic [1:0]        pj_periph_oe,
   // analog port pins
   input  wire logic [AD_W-1:0]   ad_pin_i,
   output logic [AD_W-1:0]        ad_pin_o,
   output logic [AD_W-1:0]        ad_pin_oe
);

   localparam int PL = `EGP_PJ_LSB;
   localparam int PM = `EGP_PJ_MSB;

   // bus state
   egp_wr_e               wr_state_reg;
   egp_wr_e               wr_state_next;
   egp_rd_e               rd_state_reg;
   egp_rd_e               rd_state_next;
   logic                  aw_got_reg;
   logic                  aw_got_next;
   logic                  w_got_reg;
   logic                  w_got_next;
   logic [ADDR_W-1:0]     awaddr_reg;
   logic [7:0]            wdata_reg;
   logic                  wlane_reg;
   logic                  awready_reg;
   logic                  wready_reg;
   logic                  bvalid_reg;
   logic [1:0]            bresp_reg;
   logic                  arready_reg;
   logic                  rvalid_reg;
   logic [31:0]           rdata_reg;
   logic [1:0]            rresp_reg;

   // configuration
   logic [1:0]            pj_data_reg;
   logic [1:0]            pj_direction_reg;
   logic [1:0]            pj_drive_strength_reg;
   logic [1:0]            pj_pull_enable_reg;
   logic [1:0]            pj_polarity_select_reg;
   logic [1:0]            pj_irq_enable_reg;
   logic [1:0]            pj_wired_or_reg;
   logic [AD_W-1:0]       ad_data_reg;
   logic [AD_W-1:0]       ad_direction_reg;

   // pin outputs
   logic [1:0]            pj_pin_o_reg;
   logic [1:0]            pj_pin_oe_reg;
   logic [1:0]            pj_drive_reg;
   logic [1:0]            pj_pull_en_reg;
   logic [1:0]            pj_pull_up_reg;
   logic [AD_W-1:0]       ad_pin_o_reg;
   logic [AD_W-1:0]       ad_pin_oe_reg;
   logic                  irq_reg;

   // synchronised pins and flags
   logic [1:0]            pj_sync;
   logic                  pj_primed;
   logic [AD_W-1:0]       ad_sync;
   logic [1:0]            pj_irq_flags;
   logic [1:0]            flag_clear;

   // decode and selection
   logic                  aw_fire;
   logic                  w_fire;
   logic                  ar_fire;
   logic                  wr_do;
   logic [5:0]            wr_idx;
   logic [5:0]            rd_idx;
   logic                  wr_en;
   logic                  wr_hit;
   logic                  rd_hit;
   logic [7:0]            pj_rd_data;
   logic [7:0]            pj_rd_pins;
   logic [7:0]            ad_rd_data;
   logic [7:0]            rd_byte;
   logic [1:0]            pj_out_dir;
   logic [1:0]            pj_out_val;

   // ---- bus handshakes ----
   assign aw_fire = s_axi_awvalid & awready_reg;
   assign w_fire  = s_axi_wvalid & wready_reg;
   assign ar_fire = s_axi_arvalid & arready_reg;
   assign wr_do   = aw_got_reg & w_got_reg & (wr_state_reg == EGP_WR_IDLE);
   assign wr_idx  = awaddr_reg[7:2];
   assign rd_idx  = s_axi_araddr[7:2];
   assign wr_en   = wr_do & wlane_reg;

   assign aw_got_next = wr_do ? 1'b0 : (aw_got_reg | aw_fire);
   assign w_got_next  = wr_do ? 1'b0 : (w_got_reg | w_fire);

   assign wr_state_next = wr_do ? EGP_WR_RESP :
                          ((wr_state_reg == EGP_WR_RESP) && s_axi_bready) ? EGP_WR_IDLE :
                          wr_state_reg;
   assign rd_state_next = ar_fire ? EGP_RD_DATA :
                          ((rd_state_reg == EGP_RD_DATA) && s_axi_rready) ? EGP_RD_IDLE :
                          rd_state_reg;

   // ---- address decode ----
   assign wr_hit = (wr_idx == `EGP_IDX_PJ_DATA)       ||
                   (wr_idx == `EGP_IDX_PJ_PIN_INPUT)  ||
                   (wr_idx == `EGP_IDX_PJ_DIRECTION)  ||
                   (wr_idx == `EGP_IDX_PJ_DRIVE)      ||
                   (wr_idx == `EGP_IDX_PJ_PULL)       ||
                   (wr_idx == `EGP_IDX_PJ_POLARITY)   ||
                   (wr_idx == `EGP_IDX_PJ_IRQ_ENABLE) ||
                   (wr_idx == `EGP_IDX_PJ_IRQ_FLAGS)  ||
                   (wr_idx == `EGP_IDX_AD_DATA)       ||
                   (wr_idx == `EGP_IDX_AD_PIN_INPUT)  ||
                   (wr_idx == `EGP_IDX_AD_DIRECTION)  ||
                   (wr_idx == `EGP_IDX_PJ_WIRED_OR);
   assign rd_hit = (rd_idx == `EGP_IDX_PJ_DATA)       ||
                   (rd_idx == `EGP_IDX_PJ_PIN_INPUT)  ||
                   (rd_idx == `EGP_IDX_PJ_DIRECTION)  ||
                   (rd_idx == `EGP_IDX_PJ_DRIVE)      ||
                   (rd_idx == `EGP_IDX_PJ_PULL)       ||
                   (rd_idx == `EGP_IDX_PJ_POLARITY)   ||
                   (rd_idx == `EGP_IDX_PJ_IRQ_ENABLE) ||
                   (rd_idx == `EGP_IDX_PJ_IRQ_FLAGS)  ||
                   (rd_idx == `EGP_IDX_AD_DATA)       ||
                   (rd_idx == `EGP_IDX_AD_PIN_INPUT)  ||
                   (rd_idx == `EGP_IDX_AD_DIRECTION)  ||
                   (rd_idx == `EGP_IDX_PJ_WIRED_OR);

   // write-one clear of the flags; writes to pin-input indices are dropped
   assign flag_clear = (wr_en && (wr_idx == `EGP_IDX_PJ_IRQ_FLAGS)) ?
                       wdata_reg[PM:PL] : 2'h0;

   // ---- read selection ----
   assign pj_rd_data = {(pj_direction_reg & pj_data_reg) |
                        (~pj_direction_reg & pj_sync), 6'h00};
   assign pj_rd_pins = {pj_sync, 6'h00};
   assign ad_rd_data = (ad_direction_reg & ad_data_reg) |
                       (~ad_direction_reg & ad_sync);

   assign rd_byte =
      (rd_idx == `EGP_IDX_PJ_DATA)       ? pj_rd_data :
      (rd_idx == `EGP_IDX_PJ_PIN_INPUT)  ? pj_rd_pins :
      (rd_idx == `EGP_IDX_PJ_DIRECTION)  ? {pj_direction_reg, 6'h00} :
      (rd_idx == `EGP_IDX_PJ_DRIVE)      ? {pj_drive_strength_reg, 6'h00} :
      (rd_idx == `EGP_IDX_PJ_PULL)       ? {pj_pull_enable_reg, 6'h00} :
      (rd_idx == `EGP_IDX_PJ_POLARITY)   ? {pj_polarity_select_reg, 6'h00} :
      (rd_idx == `EGP_IDX_PJ_IRQ_ENABLE) ? {pj_irq_enable_reg, 6'h00} :
      (rd_idx == `EGP_IDX_PJ_IRQ_FLAGS)  ? {pj_irq_flags, 6'h00} :
      (rd_idx == `EGP_IDX_AD_DATA)       ? ad_rd_data :
      (rd_idx == `EGP_IDX_AD_PIN_INPUT)  ? ad_sync :
      (rd_idx == `EGP_IDX_AD_DIRECTION)  ? ad_direction_reg :
      (rd_idx == `EGP_IDX_PJ_WIRED_OR)   ? {pj_wired_or_reg, 6'h00} :
      8'h00;

   // ---- pin control ----
   // a peripheral that owns the pin overrides direction and data
   assign pj_out_dir = (pj_periph_en & pj_periph_oe) |
                       (~pj_periph_en & pj_direction_reg);
   assign pj_out_val = (pj_periph_en & pj_periph_out) |
                       (~pj_periph_en & pj_data_reg);

   // ---- synchronisers and edge flags ----
   egp_sync #(.WIDTH(2)) u_pj_sync
   (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .pin_raw  (pj_pin_i),
      .pin_sync (pj_sync),
      .primed   (pj_primed)
   );

   egp_sync #(.WIDTH(AD_W)) u_ad_sync
   (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .pin_raw  (ad_pin_i),
      .pin_sync (ad_sync),
      .primed   ()
   );

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_pj_flag
         egp_edge_flag u_flag
         (
            .aclk     (aclk),
            .aresetn  (aresetn),
            .level    (pj_sync[gi]),
            .primed   (pj_primed),
            .polarity (pj_polarity_select_reg[gi]),
            .clear    (flag_clear[gi]),
            .flag     (pj_irq_flags[gi])
         );
      end
   endgenerate

   // ---- bus registers ----
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_state_reg <= EGP_WR_IDLE;
         rd_state_reg <= EGP_RD_IDLE;
         aw_got_reg   <= 1'b0;
         w_got_reg    <= 1'b0;
         awaddr_reg   <= '0;
         wdata_reg    <= 8'h00;
         wlane_reg    <= 1'b0;
         awready_reg  <= 1'b0;
         wready_reg   <= 1'b0;
         bvalid_reg   <= 1'b0;
         bresp_reg    <= `EGP_RESP_OKAY;
         arready_reg  <= 1'b0;
         rvalid_reg   <= 1'b0;
         rdata_reg    <= 32'h0000_0000;
         rresp_reg    <= `EGP_RESP_OKAY;
      end
      else
      begin
         wr_state_reg <= wr_state_next;
         rd_state_reg <= rd_state_next;
         aw_got_reg   <= aw_got_next;
         w_got_reg    <= w_got_next;
         awready_reg  <= ~aw_got_next & (wr_state_next == EGP_WR_IDLE);
         wready_reg   <= ~w_got_next & (wr_state_next == EGP_WR_IDLE);
         bvalid_reg   <= (wr_state_next == EGP_WR_RESP);
         arready_reg  <= (rd_state_next == EGP_RD_IDLE);
         rvalid_reg   <= (rd_state_next == EGP_RD_DATA);
         if (aw_fire)
         begin
            awaddr_reg <= s_axi_awaddr;
         end
         if (w_fire)
         begin
            wdata_reg <= s_axi_wdata[7:0];
            wlane_reg <= s_axi_wstrb[0];
         end
         if (wr_do)
         begin
            bresp_reg <= wr_hit ? `EGP_RESP_OKAY : `EGP_RESP_SLVERR;
         end
         if (ar_fire)
         begin
            rdata_reg <= {24'h00_0000, rd_byte};
            rresp_reg <= rd_hit ? `EGP_RESP_OKAY : `EGP_RESP_SLVERR;
         end
      end
   end

   // ---- configuration registers ----
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pj_data_reg            <= `EGP_RST_PJ;
         pj_direction_reg       <= `EGP_RST_PJ;
         pj_drive_strength_reg  <= `EGP_RST_PJ;
         pj_pull_enable_reg     <= `EGP_RST_PJ;
         pj_polarity_select_reg <= `EGP_RST_PJ;
         pj_irq_enable_reg      <= `EGP_RST_PJ;
         pj_wired_or_reg        <= `EGP_RST_PJ;
         ad_data_reg            <= `EGP_RST_AD;
         ad_direction_reg       <= `EGP_RST_AD;
      end
      else if (wr_en)
      begin
         case (wr_idx)
            `EGP_IDX_PJ_DATA:       pj_data_reg            <= wdata_reg[PM:PL];
            `EGP_IDX_PJ_DIRECTION:  pj_direction_reg       <= wdata_reg[PM:PL];
            `EGP_IDX_PJ_DRIVE:      pj_drive_strength_reg  <= wdata_reg[PM:PL];
            `EGP_IDX_PJ_PULL:       pj_pull_enable_reg     <= wdata_reg[PM:PL];
            `EGP_IDX_PJ_POLARITY:   pj_polarity_select_reg <= wdata_reg[PM:PL];
            `EGP_IDX_PJ_IRQ_ENABLE: pj_irq_enable_reg      <= wdata_reg[PM:PL];
            `EGP_IDX_PJ_WIRED_OR:   pj_wired_or_reg        <= wdata_reg[PM:PL];
            `EGP_IDX_AD_DATA:       ad_data_reg            <= wdata_reg;
            `EGP_IDX_AD_DIRECTION:  ad_direction_reg       <= wdata_reg;
            default:                pj_data_reg            <= pj_data_reg;
         endcase
      end
   end

   // ---- pin and interrupt outputs ----
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pj_pin_o_reg   <= 2'h0;
         pj_pin_oe_reg  <= 2'h0;
         pj_drive_reg   <= 2'h0;
         pj_pull_en_reg <= 2'h0;
         pj_pull_up_reg <= 2'h0;
         ad_pin_o_reg   <= `EGP_RST_AD;
         ad_pin_oe_reg  <= `EGP_RST_AD;
         irq_reg        <= 1'b0;
      end
      else
      begin
         // wired-or only ever pulls the line low
         pj_pin_o_reg   <= pj_out_val & ~pj_wired_or_reg;
         pj_pin_oe_reg  <= pj_out_dir & ~(pj_wired_or_reg & pj_out_val);
         pj_drive_reg   <= pj_out_dir & pj_drive_strength_reg;
         pj_pull_en_reg <= pj_pull_enable_reg &
                           (~pj_out_dir | pj_wired_or_reg);
         pj_pull_up_reg <= ~pj_polarity_select_reg |
                           (pj_out_dir & pj_wired_or_reg);
         ad_pin_o_reg   <= ad_data_reg;
         ad_pin_oe_reg  <= ad_direction_reg;
         irq_reg        <= |(pj_irq_flags & pj_irq_enable_reg);
      end
   end

   assign s_axi_awready    = awready_reg;
   assign s_axi_wready     = wready_reg;
   assign s_axi_bvalid     = bvalid_reg;
   assign s_axi_bresp      = bresp_reg;
   assign s_axi_arready    = arready_reg;
   assign s_axi_rvalid     = rvalid_reg;
   assign s_axi_rdata      = rdata_reg;
   assign s_axi_rresp      = rresp_reg;
   assign irq              = irq_reg;
   assign pj_pin_o         = pj_pin_o_reg;
   assign pj_pin_oe        = pj_pin_oe_reg;
   assign pj_drive_reduced = pj_drive_reg;
   assign pj_pull_enable_o = pj_pull_en_reg;
   assign pj_pull_up       = pj_pull_up_reg;
   assign ad_pin_o         = ad_pin_o_reg;
   assign ad_pin_oe        = ad_pin_oe_reg;

endmodule

/* File: egp_board.sv */
module egp_board
(
   // clock
   input  wire logic       aclk,
   // device side
   input  wire logic [1:0] pj_pin_o,
   input  wire logic [1:0] pj_pin_oe,
   input  wire logic [1:0] pj_pull_enable_o,
   input  wire logic [1:0] pj_pull_up,
   input  wire logic [7:0] ad_pin_o,
   input  wire logic [7:0] ad_pin_oe,
   // board drivers
   input  wire logic [1:0] pj_ext,
   input  wire logic [1:0] pj_ext_en,
   input  wire logic [7:0] ad_ext,
   // pin levels
   output logic      [1:0] pj_pin_i,
   output logic      [7:0] ad_pin_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] float_reg = 2'h1;
   // an undriven pin without pull wanders every cycle
   always @(posedge aclk) float_reg <= ~float_reg;
   assign pj_pin_i = (pj_pin_oe & pj_pin_o) | (~pj_pin_oe & pj_ext_en & pj_ext)
                   | (~pj_pin_oe & ~pj_ext_en & pj_pull_enable_o & pj_pull_up)
                   | (~pj_pin_oe & ~pj_ext_en & ~pj_pull_enable_o & float_reg);
   assign ad_pin_i = (ad_pin_oe & ad_pin_o) | (~ad_pin_oe & ad_ext);
endmodule

/* File: egp_top_properties.sv */
module egp_props
#(
   parameter int AD_W = 8
)
(
   // clock and reset
   input wire logic            aclk,
   input wire logic            aresetn,
   // register bus
   input wire logic            s_axi_awvalid,
   input wire logic            s_axi_awready,
   input wire logic            s_axi_wvalid,
   input wire logic            s_axi_wready,
   input wire logic            s_axi_bvalid,
   input wire logic            s_axi_bready,
   input wire logic            s_axi_arvalid,
   input wire logic            s_axi_arready,
   input wire logic [31:0]     s_axi_rdata,
   input wire logic            s_axi_rvalid,
   input wire logic            s_axi_rready,
   // pins and interrupt
   input wire logic            irq,
   input wire logic [1:0]      pj_pin_oe,
   input wire logic [1:0]      pj_pull_enable_o,
   input wire logic [1:0]      pj_pull_up,
   input wire logic [1:0]      pj_periph_en,
   input wire logic [1:0]      pj_periph_oe,
   input wire logic [AD_W-1:0] ad_pin_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_resp;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   property p_wr_ans;
      s_wr_taken |=> s_resp;
   endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("write answer off time");
   property p_rd_ans;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_bhold: assert property (p_bhold) else $error("bvalid dropped");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data not held");
   property p_pull;
      (pj_pull_enable_o & pj_pin_oe & ~pj_pull_up) == 2'h0;
   endproperty
   a_pull: assert property (p_pull) else $error("pull on push-pull output");
   property p_periph;
      &$past(pj_periph_en) && $past(aresetn) |-> pj_pin_oe == $past(pj_periph_oe);
   endproperty
   a_periph: assert property (p_periph) else $error("peripheral direction lost");
   property p_irq_fall;
      $fell(irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
   property p_ad_hold;
      $changed(ad_pin_oe) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
   endproperty
   a_ad_hold: assert property (p_ad_hold) else $error("analog direction moved");
endmodule

bind egp_top egp_props #(.AD_W(AD_W)) u_props (.*);

/* File: egp_top_tb_top.sv */
module egp_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0]  pj_pin_i, pj_pin_o, pj_pin_oe, pj_drive_reduced, pj_pull_enable_o, pj_pull_up;
   logic [1:0]  pj_periph_en = 2'h0, pj_periph_out = 2'h0, pj_periph_oe = 2'h0;
   logic [1:0]  pj_ext = 2'h0, pj_ext_en = 2'h3;
   logic [7:0]  ad_pin_i, ad_pin_o, ad_pin_oe, ad_ext = 8'h00, r, d, a;
   int          seed = 32'h35E5, n_errors = 0, cmp_count = 0, cyc = 0;
   logic [33:0] rq[$];
   logic [1:0]  bq[$];

   egp_top i_dut (.*);
   egp_board i_brd (.*);

   initial forever #4 aclk = ~aclk;

   task automatic report_and_stop();
      $display("compares %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] v, input logic s,
                     input logic [1:0] resp);
      bq.push_back(resp);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= {24'h0, v};
      s_axi_wstrb <= {3'h0, s};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         s_axi_awvalid <= s_axi_awvalid & ~s_axi_awready;
         s_axi_wvalid <= s_axi_wvalid & ~s_axi_wready;
      end
      while ((s_axi_awvalid & ~s_axi_awready) | (s_axi_wvalid & ~s_axi_wready));
      repeat ($random(seed) & 3) @(posedge aclk);
      s_axi_bready <= 1'b1;
      do
         @(posedge aclk);
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] idx, input logic [7:0] v, input logic [1:0] resp);
      rq.push_back({resp, 24'h0, v});
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      do
         @(posedge aclk);
      while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      repeat ($random(seed) & 3) @(posedge aclk);
      s_axi_rready <= 1'b1;
      do
         @(posedge aclk);
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask

   // answers are compared oldest first as they appear
   always @(posedge aclk)
   begin
      cyc++;
      if (s_axi_rvalid && s_axi_rready)
         chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
      if (s_axi_bvalid && s_axi_bready)
         chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
      if (cyc == 20000)
      begin
         n_errors++;
         report_and_stop();
      end
   end

   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (10) @(posedge aclk);
      for (int i = 6'h28; i <= 6'h32; i++)
         rd(i[5:0], 8'h00, 2'h0);
      rd(6'h10, 8'h00, 2'h2);
      wr(6'h10, 8'hFF, 1'b1, 2'h2);
      $display("test 1 done");
      for (int i = 6'h2A; i <= 6'h2E; i++)
      begin
         r = 8'($random(seed));
         wr(i[5:0], r, 1'b1, 2'h0);
         rd(i[5:0], {r[7:6], 6'h00}, 2'h0);
         wr(i[5:0], 8'h00, 1'b1, 2'h0);
      end
      wr(6'h2A, 8'hC0, 1'b0, 2'h0);
      rd(6'h2A, 8'h00, 2'h0);
      $display("test 2 done");
      wr(6'h28, 8'hC0, 1'b1, 2'h0);
      wr(6'h2A, 8'h40, 1'b1, 2'h0);
      wr(6'h2B, 8'hC0, 1'b1, 2'h0);
      wr(6'h2C, 8'hC0, 1'b1, 2'h0);
      wr(6'h2D, 8'h80, 1'b1, 2'h0);
      repeat (6) @(posedge aclk);
      rd(6'h28, 8'h40, 2'h0);
      rd(6'h29, 8'h40, 2'h0);
      chk({27'h0, pj_pin_oe, pj_drive_reduced, pj_pull_enable_o, pj_pull_up[1]}, 34'h2C);
      for (int i = 6'h28; i <= 6'h2D; i++)
         wr(i[5:0], 8'h00, 1'b1, 2'h0);
      r = 8'($random(seed));
      d = 8'($random(seed));
      a = 8'($random(seed));
      ad_ext <= a;
      wr(6'h30, r, 1'b1, 2'h0);
      wr(6'h32, d, 1'b1, 2'h0);
      wr(6'h31, ~a, 1'b1, 2'h0);
      repeat (6) @(posedge aclk);
      rd(6'h30, (r & d) | (a & ~d), 2'h0);
      rd(6'h31, (r & d) | (a & ~d), 2'h0);
      rd(6'h32, d, 2'h0);
      $display("test 3 done");
      for (int p = 0; p < 2; p++)
      begin
         pj_ext <= {2{~p[0]}};
         wr(6'h2D, {{2{p[0]}}, 6'h00}, 1'b1, 2'h0);
         wr(6'h2E, 8'h40, 1'b1, 2'h0);
         repeat (8) @(posedge aclk);
         wr(6'h2F, 8'hC0, 1'b1, 2'h0);
         pj_ext <= {p[0], ~p[0]};
         repeat (8) @(posedge aclk);
         rd(6'h2F, 8'h80, 2'h0);
         chk({33'h0, irq}, 34'h0);
         wr(6'h2E, 8'h80, 1'b1, 2'h0);
         wr(6'h2F, 8'h40, 1'b1, 2'h0);
         rd(6'h2F, 8'h80, 2'h0);
         chk({33'h0, irq}, 34'h1);
         wr(6'h2F, 8'h80, 1'b1, 2'h0);
         pj_ext <= {2{~p[0]}};
         repeat (8) @(posedge aclk);
         rd(6'h2F, 8'h00, 2'h0);
         chk({33'h0, irq}, 34'h0);
         wr(6'h2E, 8'h00, 1'b1, 2'h0);
      end
      $display("test 4 done");
      pj_periph_en <= 2'h3;
      repeat (20)
      begin
         @(posedge aclk);
         pj_periph_oe <= 2'($random(seed));
         pj_periph_out <= 2'($random(seed));
      end
      repeat (2) @(posedge aclk);
      chk({32'h0, pj_pin_oe}, {32'h0, pj_periph_oe});
      pj_periph_en <= 2'h0;
      $display("test 5 done");
      report_and_stop();
   end
endmodule
